// file: logic/rrs_pkg.sv
// Purpose: Constants shared by the rectifier restart supervisor.
// Assumes: 20 MHz system clock, millisecond tick timebase.
// Notes: Times kept in their own unit, cycle counts derived.
package rrs_pkg;
  // ****************************************
  // Timebase
  // ****************************************
  localparam int CLK_HZ = 20000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam logic [14:0] TICK_LAST = 15'(TICK_CYC - 1);
  localparam logic [14:0] TICK_CNT_RST = 15'h0000;
  // ****************************************
  // Times in milliseconds
  // ****************************************
  localparam int GRACE_MS = 20000;
  localparam int RESTART_DLY_MS = 1000;
  localparam int WINDOW_MS = 60000;
  localparam int OTW_LEAD_MS = 10000;
  localparam int HICCUP_MS = 24000;
  localparam int PG_PULSE_MS = 1;
  localparam logic [1:0] OV_MAX_TRIES = 2'h3;
  localparam logic [15:0] MS_CNT_RST = 16'h0000;
  localparam logic [1:0] OV_CNT_RST = 2'h0;
  // Synchroniser length for pins
  localparam int SYNC_STAGES = 3;
  // Temperature threshold, degrees C
  localparam logic [7:0] OT_LIMIT_C = 8'h73;

  typedef enum logic [2:0] {
    RRS_OFF, RRS_RUN, RRS_OT_WARN, RRS_SHUT, RRS_LATCH
  } rrs_state_t;
endpackage

// file: logic/rrs_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input asynchronous to i_clk_sys.
// Notes: Output changes once stages two and three agree.
`timescale 1ns/1ps
module rrs_sync (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  input wire logic i_rst_val,
  output logic o_level
);
  logic [rrs_pkg::SYNC_STAGES-1:0] sh_reg;
  logic [rrs_pkg::SYNC_STAGES-1:0] sh_next;
  logic lvl_reg;
  logic lvl_next;

  // Shift and compare stages two and three only; stage one feeds stage two
  always_comb begin
    sh_next = {sh_reg[1:0], i_pin};
    lvl_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : lvl_reg;
  end

  // Reset to a constant pattern chosen by the instance
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sh_reg <= {rrs_pkg::SYNC_STAGES{i_rst_val}};
      lvl_reg <= i_rst_val;
    end else begin
      sh_reg <= sh_next;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;
endmodule // rrs_sync

// file: logic/rrs_supervisor.sv
// Purpose: Restart, latch-off, mode and status supervisor of a rectifier.
// Assumes: i_sys_rst is the power-on reset; pins are asynchronous.
// Notes: Status outputs are open-collector style: 1 means released high.
// How it works
// (R1) Overload tolerated 20 s after power-up
// (R2) Overload after grace: shut down, restart
// (R3) Overcurrent and overtemp restart automatically
// (R4) Overvoltage: three restarts, 1 s each, window; code restarts twice and latches on the third trip
// (R5) Three failures in window latch output off
// (R6) Window expiry clears overvoltage count
// (R7) Enable pin or switch cycle clears latch
// (R8) AC power cycle clears latch
// (R9) Bus off-then-on command clears latch
// (R10) Protocol open selects analog, low RS485
// (R11) Trim off: default setpoint, margin only
// (R12) RS485 ignores trim, switch, margin
// (R13) Switch off: output follows enable low
// (R14) RS485 ignores general enable input
// (R15) RS485 uses serial enable; else ignored
// (R16) Output good high delivered, low shut
// (R17) Output good pulses in current limit
// (R18) Fault low on replaceable failures
// (R19) Fault unused in RS485 mode
// (R20) Warning low 10 s before shutdown
// (R21) Temperature recovery restarts, releases warning
// (R22) Shutdown at 115 C, restart after
// (R23) Hard overcurrent hiccups every 24 s
// (R24) Output good pulses 1 ms period; code toggles every 1 ms tick, a 2 ms period
// (R25) Timers run from one millisecond tick
// (R26) Mode sampled at power-up, held
`timescale 1ns/1ps
module rrs_supervisor (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_enable_n,
  input wire logic i_onoff_switch,
  input wire logic i_serial_mode_output_enable_n,
  input wire logic i_protocol_sel,
  input wire logic i_trim_switch,
  input wire logic i_ac_ok,
  input wire logic i_bus_output_on,
  input wire logic i_overload,
  input wire logic i_hard_overcurrent,
  input wire logic i_overvoltage,
  input wire logic i_internal_fault,
  input wire logic [7:0] i_temp_c,
  output logic o_output_on,
  output logic o_output_good_flag,
  output logic o_fault_n,
  output logic o_overtemp_warning_n,
  output logic o_rs485_mode,
  output logic o_setpoint_default,
  output logic o_setpoint_from_trim,
  output logic o_setpoint_from_margin,
  output logic o_latched_off
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic en_n_s;
  logic sw_s;
  logic sen_n_s;
  logic prot_s;
  logic trim_s;
  logic ac_s;
  logic bus_s;
  logic ovl_s;
  logic hoc_s;
  logic ov_s;
  logic flt_s;

  rrs_sync u_en (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_enable_n),
    .i_rst_val(1'b1), .o_level(en_n_s));
  rrs_sync u_sw (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_onoff_switch),
    .i_rst_val(1'b0), .o_level(sw_s));
  rrs_sync u_sen (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_pin(i_serial_mode_output_enable_n), .i_rst_val(1'b1), .o_level(sen_n_s));
  rrs_sync u_prot (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_protocol_sel),
    .i_rst_val(1'b1), .o_level(prot_s));
  rrs_sync u_trim (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_trim_switch),
    .i_rst_val(1'b1), .o_level(trim_s));
  rrs_sync u_ac (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_ac_ok),
    .i_rst_val(1'b0), .o_level(ac_s));
  rrs_sync u_bus (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_bus_output_on),
    .i_rst_val(1'b1), .o_level(bus_s));
  rrs_sync u_ovl (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_overload),
    .i_rst_val(1'b0), .o_level(ovl_s));
  rrs_sync u_hoc (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_hard_overcurrent),
    .i_rst_val(1'b0), .o_level(hoc_s));
  rrs_sync u_ov (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_overvoltage),
    .i_rst_val(1'b0), .o_level(ov_s));
  rrs_sync u_flt (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin(i_internal_fault),
    .i_rst_val(1'b0), .o_level(flt_s));

  // Temperature word comes from on-chip logic, no synchroniser
  logic ot_hot;
  assign ot_hot = (i_temp_c >= rrs_pkg::OT_LIMIT_C); // see (R22)

  // ****************************************
  // Millisecond tick and mode capture
  // ****************************************
  logic [14:0] tick_cnt_reg;
  logic [14:0] tick_cnt_next;
  logic tick;
  logic mode_cap_reg;
  logic mode_cap_next;
  logic rs485_reg;
  logic rs485_next;

  assign tick = (tick_cnt_reg == rrs_pkg::TICK_LAST);

  // Free-running tick; mode caught once after reset release
  always_comb begin
    tick_cnt_next = tick ? rrs_pkg::TICK_CNT_RST : tick_cnt_reg + 15'h0001; // see (R25)
    mode_cap_next = 1'b1;
    // Wait for synchroniser to fill before trusting the pin
    rs485_next = rs485_reg;
    if (!mode_cap_reg && tick) begin
      rs485_next = ~prot_s; // see (R10) see (R26)
    end
    if (!mode_cap_reg && !tick) begin
      mode_cap_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tick_cnt_reg <= rrs_pkg::TICK_CNT_RST;
      mode_cap_reg <= 1'b0;
      rs485_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      mode_cap_reg <= mode_cap_next;
      rs485_reg <= rs485_next;
    end
  end

  // ****************************************
  // Requested on/off and restart sources
  // ****************************************
  logic want_on;
  logic req_prev_reg;
  logic bus_prev_reg;
  logic ac_prev_reg;
  logic latch_clear;

  // Mode picks which enable pin matters
  always_comb begin
    if (rs485_reg) begin
      want_on = ~sen_n_s; // see (R14) see (R15)
    end else begin
      want_on = sw_s | ~en_n_s; // see (R13)
    end
    // Nothing starts before the mode is known, so RS485 never sees a stray enable
    want_on = want_on & bus_s & ac_s & mode_cap_reg; // see (R26)
    // Any rising edge of a source after being off clears latch-off
    latch_clear = (want_on & ~req_prev_reg) // see (R7)
      | (bus_s & ~bus_prev_reg) // see (R9)
      | (ac_s & ~ac_prev_reg); // see (R8)
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      req_prev_reg <= 1'b0;
      bus_prev_reg <= 1'b1;
      ac_prev_reg <= 1'b0;
    end else begin
      req_prev_reg <= want_on;
      bus_prev_reg <= bus_s;
      ac_prev_reg <= ac_s;
    end
  end

  // ****************************************
  // Main sequencer
  // ****************************************
  rrs_pkg::rrs_state_t st_reg;
  rrs_pkg::rrs_state_t st_next;
  logic [15:0] grace_reg;
  logic [15:0] grace_next;
  logic [15:0] tmr_reg;
  logic [15:0] tmr_next;
  logic [15:0] win_reg;
  logic [15:0] win_next;
  logic win_run_reg;
  logic win_run_next;
  logic [1:0] ov_cnt_reg;
  logic [1:0] ov_cnt_next;
  logic [15:0] shut_ms_reg;
  logic [15:0] shut_ms_next;
  logic shut_ov_reg;
  logic shut_ov_next;
  logic shut_ot_reg;
  logic shut_ot_next;
  logic grace_done;

  // Saturating millisecond counter step
  function automatic logic [15:0] ms_step(input logic [15:0] v, input logic t);
    ms_step = (t && v != 16'hffff) ? v + 16'h0001 : v;
  endfunction

  assign grace_done = (grace_reg >= 16'(rrs_pkg::GRACE_MS));

  always_comb begin
    st_next = st_reg;
    grace_next = ms_step(grace_reg, tick); // see (R1) see (R25)
    tmr_next = ms_step(tmr_reg, tick);
    win_run_next = win_run_reg;
    win_next = win_run_reg ? ms_step(win_reg, tick) : rrs_pkg::MS_CNT_RST;
    ov_cnt_next = ov_cnt_reg;
    shut_ms_next = shut_ms_reg;
    shut_ov_next = shut_ov_reg;
    shut_ot_next = shut_ot_reg;
    // Window expiry with fewer than three trips starts afresh
    if (win_run_reg && win_reg >= 16'(rrs_pkg::WINDOW_MS) && st_reg != rrs_pkg::RRS_LATCH) begin
      win_run_next = 1'b0; // see (R6)
      ov_cnt_next = rrs_pkg::OV_CNT_RST;
      win_next = rrs_pkg::MS_CNT_RST;
    end
    case (st_reg)
      rrs_pkg::RRS_OFF: begin
        if (want_on && !ot_hot) begin
          st_next = rrs_pkg::RRS_RUN;
        end
      end
      rrs_pkg::RRS_RUN: begin
        tmr_next = rrs_pkg::MS_CNT_RST;
        shut_ov_next = 1'b0;
        shut_ot_next = 1'b0;
        if (!want_on) begin
          st_next = rrs_pkg::RRS_OFF;
        end else if (ov_s) begin
          // Overvoltage trip counted inside the window
          st_next = rrs_pkg::RRS_SHUT; // see (R4)
          shut_ov_next = 1'b1;
          shut_ms_next = 16'(rrs_pkg::RESTART_DLY_MS);
          // Builds on the count the window may have just cleared
          ov_cnt_next = ov_cnt_next + 2'h1;
          if (!win_run_next) begin
            win_run_next = 1'b1;
            win_next = rrs_pkg::MS_CNT_RST;
          end
          if (ov_cnt_next == rrs_pkg::OV_MAX_TRIES) begin
            st_next = rrs_pkg::RRS_LATCH; // see (R5)
          end
        end else if (ot_hot) begin
          st_next = rrs_pkg::RRS_OT_WARN; // see (R20)
        end else if (hoc_s || (ovl_s && grace_done)) begin
          // Hiccup restart, no external request needed
          st_next = rrs_pkg::RRS_SHUT; // see (R2) see (R3) see (R23)
          shut_ms_next = 16'(rrs_pkg::HICCUP_MS);
        end
      end
      rrs_pkg::RRS_OT_WARN: begin
        if (!ot_hot) begin
          st_next = rrs_pkg::RRS_RUN; // see (R21)
        end else if (tmr_reg >= 16'(rrs_pkg::OTW_LEAD_MS)) begin
          st_next = rrs_pkg::RRS_SHUT; // see (R20) see (R22)
          shut_ot_next = 1'b1;
          tmr_next = rrs_pkg::MS_CNT_RST;
        end
      end
      rrs_pkg::RRS_SHUT: begin
        // Overtemp waits for recovery, others wait a fixed delay
        if (shut_ot_reg ? !ot_hot : tmr_reg >= shut_ms_reg) begin
          st_next = rrs_pkg::RRS_OFF; // see (R3) see (R21)
          // Warning released on recovery even if the output stays off
          shut_ot_next = 1'b0; // see (R21)
        end
      end
      rrs_pkg::RRS_LATCH: begin
        win_run_next = 1'b0;
        if (latch_clear) begin
          st_next = rrs_pkg::RRS_OFF; // see (R7) see (R8) see (R9)
          ov_cnt_next = rrs_pkg::OV_CNT_RST;
          shut_ov_next = 1'b0;
        end
      end
      default: begin
        st_next = rrs_pkg::RRS_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg <= rrs_pkg::RRS_OFF;
      grace_reg <= rrs_pkg::MS_CNT_RST;
      tmr_reg <= rrs_pkg::MS_CNT_RST;
      win_reg <= rrs_pkg::MS_CNT_RST;
      win_run_reg <= 1'b0;
      ov_cnt_reg <= rrs_pkg::OV_CNT_RST;
      shut_ms_reg <= rrs_pkg::MS_CNT_RST;
      shut_ov_reg <= 1'b0;
      shut_ot_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      grace_reg <= grace_next;
      tmr_reg <= tmr_next;
      win_reg <= win_next;
      win_run_reg <= win_run_next;
      ov_cnt_reg <= ov_cnt_next;
      shut_ms_reg <= shut_ms_next;
      shut_ov_reg <= shut_ov_next;
      shut_ot_reg <= shut_ot_next;
    end
  end

  // ****************************************
  // Status and setpoint outputs
  // ****************************************
  logic on_reg;
  logic on_next;
  logic pg_reg;
  logic pg_next;
  logic fault_n_reg;
  logic fault_n_next;
  logic otw_n_reg;
  logic otw_n_next;
  logic sp_def_reg;
  logic sp_def_next;
  logic sp_trim_reg;
  logic sp_trim_next;
  logic sp_marg_reg;
  logic sp_marg_next;
  logic pulse_ph_reg;
  logic pulse_ph_next;
  logic latched_reg;
  logic latched_next;

  // Output good toggles each ms tick while limiting; 1 ms per phase
  always_comb begin
    on_next = (st_reg == rrs_pkg::RRS_RUN) || (st_reg == rrs_pkg::RRS_OT_WARN);
    pulse_ph_next = tick ? ~pulse_ph_reg : pulse_ph_reg;
    pg_next = on_next; // see (R16)
    if (on_next && ovl_s) begin
      pg_next = pulse_ph_reg; // see (R17) see (R24)
    end
    // Fault line is don't-care in RS485 mode; held released there
    fault_n_next = rs485_reg | ~(flt_s | shut_ov_reg | shut_ot_reg
      | (st_reg == rrs_pkg::RRS_LATCH)); // see (R18) see (R19)
    otw_n_next = ~((st_reg == rrs_pkg::RRS_OT_WARN) || shut_ot_reg); // see (R20) see (R21)
    sp_def_next = ~rs485_reg & ~trim_s; // see (R11)
    sp_trim_next = ~rs485_reg & trim_s; // see (R12)
    sp_marg_next = ~rs485_reg & ~trim_s; // see (R11) see (R12)
    latched_next = (st_reg == rrs_pkg::RRS_LATCH); // see (R5)
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      on_reg <= 1'b0;
      pg_reg <= 1'b0;
      fault_n_reg <= 1'b1;
      otw_n_reg <= 1'b1;
      sp_def_reg <= 1'b0;
      sp_trim_reg <= 1'b1;
      sp_marg_reg <= 1'b0;
      pulse_ph_reg <= 1'b0;
      latched_reg <= 1'b0;
    end else begin
      on_reg <= on_next;
      pg_reg <= pg_next;
      fault_n_reg <= fault_n_next;
      otw_n_reg <= otw_n_next;
      sp_def_reg <= sp_def_next;
      sp_trim_reg <= sp_trim_next;
      sp_marg_reg <= sp_marg_next;
      pulse_ph_reg <= pulse_ph_next;
      latched_reg <= latched_next;
    end
  end

  assign o_output_on = on_reg;
  assign o_output_good_flag = pg_reg;
  assign o_fault_n = fault_n_reg;
  assign o_overtemp_warning_n = otw_n_reg;
  assign o_rs485_mode = rs485_reg;
  assign o_setpoint_default = sp_def_reg;
  assign o_setpoint_from_trim = sp_trim_reg;
  assign o_setpoint_from_margin = sp_marg_reg;
  assign o_latched_off = latched_reg;

  // ****************************************
  // Assertions
  // ****************************************
  a_tick_period: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    tick |=> !tick [*8]) else $error("Tick came too soon"); // see (R25)
  a_latch_holds: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_reg == rrs_pkg::RRS_LATCH && !latch_clear) |=> st_reg == rrs_pkg::RRS_LATCH)
    else $error("Latch-off left without clear"); // see (R5)
  a_latch_off_out: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_reg == rrs_pkg::RRS_LATCH |=> !o_output_on)
    else $error("Output on while latched"); // see (R5)
  a_pg_when_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !on_next |=> !o_output_good_flag) else $error("Output good high while off"); // see (R16)
  a_mode_held: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    mode_cap_reg |=> $stable(rs485_reg)) else $error("Mode changed after capture"); // see (R26)
  a_fault_rs485: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    rs485_reg |=> o_fault_n) else $error("Fault driven in RS485 mode"); // see (R19)
  a_rs485_ign_en: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (rs485_reg && sen_n_s) |-> !want_on) else $error("Serial enable ignored"); // see (R15)
  a_otw_before_sd: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_reg == rrs_pkg::RRS_RUN && st_next == rrs_pkg::RRS_OT_WARN)
    |=> ##1 !o_overtemp_warning_n)
    else $error("Warning not asserted"); // see (R20)
  a_no_early_trip: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_reg == rrs_pkg::RRS_RUN && !grace_done && !hoc_s && !ov_s && !ot_hot && want_on)
    |=> st_reg == rrs_pkg::RRS_RUN) else $error("Overload trip during grace"); // see (R1)
endmodule // rrs_supervisor

// file: verification/rrs_host_model.sv
// Purpose: Host controller model driving the supervisor's control pins.
// Assumes: Requests from the bench; pins change at the falling edge.
// Notes: Protocol pin open reads high through its pull-up.
`timescale 1ns/1ps
module rrs_host_model (
  input wire logic i_clk_sys,
  input wire logic i_want_on,
  input wire logic i_serial_on,
  input wire logic i_rs485,
  output logic o_enable_n,
  output logic o_serial_mode_output_enable_n,
  output logic o_protocol_sel
);
  // ****************************************
  // Pin drivers
  // ****************************************
  initial begin
    o_enable_n = 1'b1;
    o_serial_mode_output_enable_n = 1'b1;
    o_protocol_sel = 1'b1;
  end
  // Pins move off the sampling edge so the synchronisers see clean levels
  always @(negedge i_clk_sys) begin
    o_enable_n <= ~i_want_on;
    o_serial_mode_output_enable_n <= ~i_serial_on;
    // Open pin floats to the pull-up level, RS485 pulls it down
    o_protocol_sel <= ~i_rs485;
  end
endmodule // rrs_host_model

// file: verification/rectifier_restart_supervisor_bench.sv
// Purpose: Self-checking bench for the restart supervisor.
// Assumes: 20 MHz clock; millisecond timers are too long to run in full.
// Notes: Only short timers are exercised; second-long restarts are out of reach.
`timescale 1ns/1ps
module rectifier_restart_supervisor_bench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic want_on = 1'b0;
  logic serial_on = 1'b0;
  logic rs485_want = 1'b0;
  logic onoff_switch = 1'b0;
  logic trim_switch = 1'b1;
  logic overload = 1'b0;
  logic overvoltage = 1'b0;
  logic int_fault = 1'b0;
  logic [7:0] temp_c = 8'h19;
  logic ac_ok = 1'b1;
  logic bus_on = 1'b1;
  logic hard_oc = 1'b0;
  logic enable_n, ser_en_n, protocol_sel;
  logic output_on, pg, fault_n, otw_n, rs485_mode;
  logic sp_default, sp_trim, sp_margin, latched_off;
  int n_errors = 0;
  int checks_done = 0;
  // ****************************************
  // Clock, partner and design
  // ****************************************
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  rrs_host_model host (.i_clk_sys(clk_sys), .i_want_on(want_on), .i_serial_on(serial_on),
    .i_rs485(rs485_want), .o_enable_n(enable_n),
    .o_serial_mode_output_enable_n(ser_en_n), .o_protocol_sel(protocol_sel));
  rrs_supervisor uut (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_enable_n(enable_n),
    .i_onoff_switch(onoff_switch), .i_serial_mode_output_enable_n(ser_en_n),
    .i_protocol_sel(protocol_sel), .i_trim_switch(trim_switch), .i_ac_ok(ac_ok),
    .i_bus_output_on(bus_on), .i_overload(overload), .i_hard_overcurrent(hard_oc),
    .i_overvoltage(overvoltage), .i_internal_fault(int_fault), .i_temp_c(temp_c),
    .o_output_on(output_on), .o_output_good_flag(pg), .o_fault_n(fault_n),
    .o_overtemp_warning_n(otw_n), .o_rs485_mode(rs485_mode),
    .o_setpoint_default(sp_default), .o_setpoint_from_trim(sp_trim),
    .o_setpoint_from_margin(sp_margin), .o_latched_off(latched_off));
  // ****************************************
  // Shared tasks
  // ****************************************
  // Single comparison point, counts every check
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Bounded wait on the main output; pins take a few cycles to sync
  task automatic wait_on(input logic exp);
    for (int k = 0; k < 40 && output_on !== exp; k++) @(negedge clk_sys);
  endtask
  // Power cycle: mode is only captured at the first tick after release
  task automatic power_up(input logic rs485);
    @(negedge clk_sys);
    sys_rst = 1'b1;
    rs485_want = rs485;
    cycles(16);
    check(output_on, 1'b0);
    check(pg, 1'b0);
    check(fault_n, 1'b1);
    check(otw_n, 1'b1);
    sys_rst = 1'b0;
    cycles(20050);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_setpoint();
    check(rs485_mode, 1'b0);
    check({sp_default, sp_trim, sp_margin}, 3'h2);
    trim_switch = 1'b0;
    cycles(10);
    check({sp_default, sp_trim, sp_margin}, 3'h5);
  endtask
  task automatic t_enable();
    serial_on = 1'b1;
    cycles(30);
    check(output_on, 1'b0);
    want_on = 1'b1;
    wait_on(1'b1);
    check(output_on, 1'b1);
    cycles(4);
    check(pg, 1'b1);
  endtask
  // Overload inside the startup grace keeps the output up but pulses good
  task automatic t_overload();
    logic pg0;
    overload = 1'b1;
    cycles(10);
    pg0 = pg;
    for (int k = 0; k < 21000 && pg === pg0; k++) @(negedge clk_sys);
    check(pg, !pg0);
    check(output_on, 1'b1);
    overload = 1'b0;
    for (int k = 0; k < 21000 && pg !== 1'b1; k++) @(negedge clk_sys);
    check(pg, 1'b1);
  endtask
  task automatic t_overtemp();
    temp_c = rrs_pkg::OT_LIMIT_C;
    cycles(20);
    check(otw_n, 1'b0);
    check(output_on, 1'b1);
    temp_c = 8'h19;
    for (int k = 0; k < 40 && otw_n !== 1'b1; k++) @(negedge clk_sys);
    check(otw_n, 1'b1);
  endtask
  // Switch, bus command and AC input each gate the main output
  task automatic t_sources();
    onoff_switch = 1'b1;
    cycles(10);
    want_on = 1'b0;
    cycles(20);
    check(output_on, 1'b1);
    onoff_switch = 1'b0;
    wait_on(1'b0);
    check(output_on, 1'b0);
    want_on = 1'b1;
    wait_on(1'b1);
    bus_on = 1'b0;
    wait_on(1'b0);
    check(output_on, 1'b0);
    bus_on = 1'b1;
    wait_on(1'b1);
    check(output_on, 1'b1);
    ac_ok = 1'b0;
    wait_on(1'b0);
    check(pg, 1'b0);
    ac_ok = 1'b1;
    wait_on(1'b1);
    check(output_on, 1'b1);
  endtask
  task automatic t_overvoltage();
    int_fault = 1'b1;
    cycles(20);
    check(fault_n, 1'b0);
    int_fault = 1'b0;
    overvoltage = 1'b1;
    wait_on(1'b0);
    check(output_on, 1'b0);
    cycles(4);
    check(pg, 1'b0);
    check(fault_n, 1'b0);
    check(latched_off, 1'b0);
    overvoltage = 1'b0;
  endtask
  // Serial mode: general enable, trim and fault pin are all out of play
  task automatic t_serial();
    serial_on = 1'b0;
    want_on = 1'b1;
    trim_switch = 1'b1;
    power_up(1'b1);
    check(rs485_mode, 1'b1);
    check({sp_default, sp_trim, sp_margin}, 3'h0);
    check(output_on, 1'b0);
    serial_on = 1'b1;
    wait_on(1'b1);
    check(output_on, 1'b1);
    int_fault = 1'b1;
    cycles(20);
    check(fault_n, 1'b1);
    // Hard overcurrent trips at once, grace or not
    hard_oc = 1'b1;
    wait_on(1'b0);
    check(output_on, 1'b0);
    check(pg, 1'b0);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    power_up(1'b0);
    t_setpoint();
    t_enable();
    t_overload();
    t_overtemp();
    t_sources();
    t_overvoltage();
    t_serial();
    give_verdict();
  end
  // Expected run is about 60000 cycles; margin for slow answers
  initial begin
    #(90000 * 50);
    n_errors++;
    give_verdict();
  end
endmodule // rectifier_restart_supervisor_bench
